//--- byte_down_counter.sv
`timescale 1ns/100ps
`default_nettype none
module byte_down_counter (
  // Clock and reset
  input wire logic  mclk,
  input wire logic  rst,
  // Control side
  counter_if.counter port
);

  typedef struct packed {
    logic [7:0] count;
    logic       underflow;
  } state_s;

  state_s s_q;
  state_s s_d;

  // ==========================================
  // Count
  always_comb begin
    s_d           = s_q;
    s_d.underflow = 1'b0;
    if (port.wrEn) begin
      s_d.count = port.wrData;
    end else if (port.clear) begin
      s_d.count = 8'h00;
    end else if (port.tick) begin
      if (s_q.count == 8'h00) begin
        s_d.count     = port.period;
        s_d.underflow = 1'b1;
      end else begin
        s_d.count = s_q.count - 8'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign port.count     = s_q.count;
  assign port.underflow = s_q.underflow;

endmodule : byte_down_counter
`default_nettype wire

//--- counter_if.sv
`timescale 1ns/100ps
`default_nettype none
interface counter_if;
  logic       tick;
  logic       clear;
  logic       wrEn;
  logic [7:0] wrData;
  logic [7:0] period;
  logic [7:0] count;
  logic       underflow;

  modport control (output tick, clear, wrEn, wrData, period, input count, underflow);
  modport counter (input tick, clear, wrEn, wrData, period, output count, underflow);
endinterface : counter_if
`default_nettype wire

//--- split_timer_ctrl.sv
// Notes on behaviour
// - Split bit set runs the timer as independent low and high 8-bit timers.
// - Split mode changes register decoding away from the 16-bit map.
// - Low output enable bits 0..2 route waveform to outputs 0..2.
// - High output enable bits 4..6 route waveform to outputs 3..5.
// - Timer disabled: low force value bits 0..2 drive compare outputs 0..2.
// - Timer disabled: high force value bits 4..6 drive compare outputs 3..5.
// - Clear alias write clears control bits written as one.
// - Set alias write sets control bits written as one.
// - Command field bits 3:2 is a strobe and reads zero.
// - Command 2 restarts counters, 3 hard resets unless timer enabled.
// - Target field 3 applies command to both timers, others to none.
// - Enable bits 4..6 let low compare flags raise the interrupt.
// - Enable bits 1 and 0 let high and low underflow flags interrupt.
// - Low compare flag sets when low counter equals its compare value.
// - Compare flags stay set until software writes one there.
// - High underflow flag sets at high bottom, cleared by writing one.
// - Low underflow flag sets at low bottom, cleared by writing one.
// - Debug halt stops counting unless run-while-halted bit is one.
// - Prescale select picks divide by 1,2,4,8,16,64,256,1024.
// - Even compare registers are compared against the low counter, odd ones against the high counter, on each tick.
// - Bus write to a counter beats count, clear or reload that cycle.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module split_timer_ctrl (
  // Clock and reset
  input  wire logic                              mclk,
  input  wire logic                              rst,
  // Avalon-MM slave
  input  wire logic [split_timer_pkg::ADDR_W-1:0] address,
  input  wire logic                              read,
  input  wire logic                              write,
  input  wire logic [split_timer_pkg::DATA_W-1:0] writedata,
  input  wire logic [3:0]                        byteenable,
  output logic      [split_timer_pkg::DATA_W-1:0] readdata,
  output logic                                   waitrequest,
  // Debug and port
  input  wire logic                              cpuHalted,
  input  wire logic [5:0]                        portOutValue,
  // Outputs
  output logic      [5:0]                        waveformOutput,
  output logic                                   irqRequest
);
  import split_timer_pkg::*;

  // ==========================================
  // State
  typedef struct packed {
    logic              waitReq;
    logic [DATA_W-1:0] rdata;
    logic [7:0]        ctrlA;
    logic [7:0]        outEnable;
    logic [7:0]        outValue;
    logic [7:0]        splitCfg;
    logic [1:0]        target;
    logic [7:0]        irqEnable;
    logic [7:0]        flags;
    logic [7:0]        debugCtrl;
    logic [7:0]        lowPeriod;
    logic [7:0]        highPeriod;
    logic [5:0][7:0]   cmp;
    logic [PRESC_W-1:0] presc;
    logic [5:0]        cmpOut;
    logic [5:0]        wave;
    logic              irq;
  } state_s;

  localparam state_s RESET_STATE = '{
    waitReq:    1'b1,
    lowPeriod:  PERIOD_RESET,
    highPeriod: PERIOD_RESET,
    default:    '0
  };

  state_s s_q;
  state_s s_d;

  counter_if lowIf ();
  counter_if highIf ();

  // ==========================================
  // Counters
  byte_down_counter lowCounter (
    .mclk (mclk),
    .rst  (rst),
    .port (lowIf.counter)
  );

  byte_down_counter highCounter (
    .mclk (mclk),
    .rst  (rst),
    .port (highIf.counter)
  );

  // ==========================================
  // Decode and next state
  logic [IDX_W-1:0]   idx;
  logic [7:0]         wByte;
  logic               doWrite;
  logic               doRead;
  logic               splitOn;
  logic               timerOn;
  logic               running;
  logic               prescTick;
  logic               tick;
  logic [1:0]         newTarget;
  logic [1:0]         cmdCode;
  logic               cmdWrite;
  logic               restart;
  logic               hardReset;
  logic [2:0]         lowMatch;
  logic [2:0]         highMatch;
  logic [7:0]         flagSet;
  logic [7:0]         flagClr;
  logic [7:0]         rByte;
  logic [2:0]         cmpIdx;
  logic               lowWr;
  logic               highWr;
  int                 bitPos;

  always_comb begin
    s_d       = s_q;
    idx       = address[ADDR_W-1:2];
    wByte     = writedata[7:0];
    doWrite   = write && !s_q.waitReq && byteenable[0];
    doRead    = read && s_q.waitReq;
    splitOn   = s_q.splitCfg[SPLIT_BIT];
    timerOn   = s_q.ctrlA[ENABLE_BIT];
    running   = timerOn && splitOn && (!cpuHalted || s_q.debugCtrl[RUN_HALT_BIT]);
    prescTick = (s_q.presc & PRESCALE_MASK[s_q.ctrlA[PRESC_LSB+:3]])
                == PRESCALE_MASK[s_q.ctrlA[PRESC_LSB+:3]];
    tick      = running && prescTick;
    newTarget = s_q.target;
    cmdCode   = wByte[CMD_LSB+:2];
    cmdWrite  = 1'b0;
    restart   = 1'b0;
    hardReset = 1'b0;
    lowWr     = 1'b0;
    highWr    = 1'b0;
    flagClr   = 8'h00;
    cmpIdx    = 3'd0;
    rByte     = 8'h00;
    bitPos    = 0;

    // Bus handshake: one wait state, then a single ready cycle
    s_d.waitReq = !((read || write) && s_q.waitReq);

    // Register writes
    if (doWrite) begin
      if (idx == IDX_CTRL_A) begin
        s_d.ctrlA = wByte & CTRL_A_MASK;
      end else if (idx == IDX_SPLIT_CFG) begin
        s_d.splitCfg = wByte & BIT0_MASK;
      end else if (idx == IDX_DEBUG_CTRL) begin
        s_d.debugCtrl = wByte & BIT0_MASK;
      end else if (!splitOn) begin
        // Normal-mode map is not decoded here
        s_d.splitCfg = s_q.splitCfg;
      end else if (idx == IDX_OUT_ENABLE) begin
        s_d.outEnable = wByte & OUT_MASK;
      end else if (idx == IDX_OUT_VALUE) begin
        s_d.outValue = wByte & OUT_MASK;
      end else if (idx == IDX_CMD_CLEAR) begin
        newTarget = s_q.target & ~wByte[TARGET_LSB+:2];
        cmdWrite  = 1'b1;
      end else if (idx == IDX_CMD_SET) begin
        newTarget = s_q.target | wByte[TARGET_LSB+:2];
        cmdWrite  = 1'b1;
      end else if (idx == IDX_IRQ_ENABLE) begin
        s_d.irqEnable = wByte & FLAG_MASK;
      end else if (idx == IDX_IRQ_FLAGS) begin
        flagClr = wByte & FLAG_MASK;
      end else if (idx == IDX_LOW_COUNT) begin
        lowWr = 1'b1;
      end else if (idx == IDX_HIGH_COUNT) begin
        highWr = 1'b1;
      end else if (idx == IDX_LOW_PERIOD) begin
        s_d.lowPeriod = wByte;
      end else if (idx == IDX_HIGH_PERIOD) begin
        s_d.highPeriod = wByte;
      end else if (idx >= IDX_CMP_FIRST && idx <= IDX_CMP_LAST) begin
        cmpIdx = 3'(idx - IDX_CMP_FIRST);
        s_d.cmp[cmpIdx] = wByte;
      end
    end

    // Commands: strobe only, never stored
    s_d.target = newTarget;
    if (cmdWrite && newTarget == TARGET_BOTH) begin
      if (cmdCode == CMD_RESTART) begin
        restart = 1'b1;
      end else if (cmdCode == CMD_HARD_RESET && !timerOn) begin
        hardReset = 1'b1;
      end
    end

    // Prescaler
    if (!running || restart || hardReset) begin
      s_d.presc = '0;
    end else begin
      s_d.presc = s_q.presc + 10'h001;
    end

    // Compare matches
    for (int c = 0; c < CHANNELS; c++) begin
      lowMatch[c]  = tick && (lowIf.count == s_q.cmp[2*c]);
      highMatch[c] = tick && (highIf.count == s_q.cmp[2*c+1]);
    end

    // Flags: a new event wins over a clear in the same cycle
    flagSet = 8'h00;
    flagSet[LOW_UNF_BIT]  = lowIf.underflow;
    flagSet[HIGH_UNF_BIT] = highIf.underflow;
    for (int c = 0; c < CHANNELS; c++) begin
      flagSet[LOW_CMP_LSB+c] = lowMatch[c];
    end
    s_d.flags = ((s_q.flags & ~flagClr) | flagSet) & FLAG_MASK;

    // Compare outputs and pin mux
    for (int k = 0; k < 6; k++) begin
      bitPos = (k < CHANNELS) ? k : k + 1;
      if (!timerOn) begin
        s_d.cmpOut[k] = s_q.outValue[bitPos];
      end else if (restart) begin
        s_d.cmpOut[k] = 1'b0;
      end else if (k < CHANNELS && lowMatch[k]) begin
        s_d.cmpOut[k] = 1'b1;
      end else if (k >= CHANNELS && highMatch[k-CHANNELS]) begin
        s_d.cmpOut[k] = 1'b1;
      end else if (k < CHANNELS && lowIf.underflow) begin
        s_d.cmpOut[k] = 1'b0;
      end else if (k >= CHANNELS && highIf.underflow) begin
        s_d.cmpOut[k] = 1'b0;
      end
      if (splitOn && s_q.outEnable[bitPos]) begin
        s_d.wave[k] = s_q.cmpOut[k];
      end else begin
        s_d.wave[k] = portOutValue[k];
      end
    end

    // Hard reset returns the split-mode state to defaults
    if (hardReset) begin
      s_d.outEnable  = REG_RESET;
      s_d.outValue   = REG_RESET;
      s_d.target     = TARGET_NONE;
      s_d.irqEnable  = REG_RESET;
      s_d.flags      = REG_RESET;
      s_d.lowPeriod  = PERIOD_RESET;
      s_d.highPeriod = PERIOD_RESET;
      s_d.cmp        = '0;
      s_d.cmpOut     = '0;
    end

    s_d.irq = |(s_q.flags & s_q.irqEnable);

    // Read data, captured with the wait state
    if (idx == IDX_CTRL_A) begin
      rByte = s_q.ctrlA;
    end else if (idx == IDX_SPLIT_CFG) begin
      rByte = s_q.splitCfg;
    end else if (idx == IDX_DEBUG_CTRL) begin
      rByte = s_q.debugCtrl;
    end else if (!splitOn) begin
      rByte = 8'h00;
    end else if (idx == IDX_OUT_ENABLE) begin
      rByte = s_q.outEnable;
    end else if (idx == IDX_OUT_VALUE) begin
      rByte = s_q.outValue;
    end else if (idx == IDX_CMD_CLEAR || idx == IDX_CMD_SET) begin
      rByte = {6'h00, s_q.target};
    end else if (idx == IDX_IRQ_ENABLE) begin
      rByte = s_q.irqEnable;
    end else if (idx == IDX_IRQ_FLAGS) begin
      rByte = s_q.flags;
    end else if (idx == IDX_LOW_COUNT) begin
      rByte = lowIf.count;
    end else if (idx == IDX_HIGH_COUNT) begin
      rByte = highIf.count;
    end else if (idx == IDX_LOW_PERIOD) begin
      rByte = s_q.lowPeriod;
    end else if (idx == IDX_HIGH_PERIOD) begin
      rByte = s_q.highPeriod;
    end else if (idx >= IDX_CMP_FIRST && idx <= IDX_CMP_LAST) begin
      rByte = s_q.cmp[3'(idx - IDX_CMP_FIRST)];
    end
    if (doRead) begin
      s_d.rdata = {24'h000000, rByte};
    end
  end

  // ==========================================
  // Counter controls
  // Count reads lag a write by one cycle, the counter owns its value
  assign lowIf.tick    = tick;
  assign lowIf.clear   = restart || hardReset;
  assign lowIf.wrEn    = lowWr;
  assign lowIf.wrData  = wByte;
  assign lowIf.period  = s_q.lowPeriod;
  assign highIf.tick   = tick;
  assign highIf.clear  = restart || hardReset;
  assign highIf.wrEn   = highWr;
  assign highIf.wrData = wByte;
  assign highIf.period = s_q.highPeriod;

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // Outputs
  assign readdata       = s_q.rdata;
  assign waitrequest    = s_q.waitReq;
  assign waveformOutput = s_q.wave;
  assign irqRequest     = s_q.irq;

endmodule : split_timer_ctrl
`default_nettype wire

//--- split_timer_ctrl_checker.sv
`timescale 1ns/100ps
`default_nettype none
module split_timer_ctrl_checker (
  // Clock and reset
  input wire logic                                mclk,
  input wire logic                                rst,
  // Register bus
  input wire logic [split_timer_pkg::ADDR_W-1:0] address,
  input wire logic                                read,
  input wire logic                                write,
  input wire logic [split_timer_pkg::DATA_W-1:0] readdata,
  input wire logic                                waitrequest,
  // Interrupt
  input wire logic                                irqRequest
);
  import split_timer_pkg::*;

  // ======================================
  // Bus answer timing
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  wait_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered after one wait state");
  wait_single_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  data_stands_a: assert property (!read |=> $stable(readdata))
    else $error("readdata changed without a read");
  upper_zero_a: assert property (readdata[31:8] == 24'h000000)
    else $error("readdata upper bits not zero");

  // ======================================
  // Read values of mapped fields and unmapped indices
  cmd_strobe_a: assert property (read && !waitrequest &&
      (address[7:2] == IDX_CMD_CLEAR || address[7:2] == IDX_CMD_SET) |-> readdata[7:2] == 6'h00)
    else $error("command alias reads nonzero command bits");
  flag_mask_a: assert property (read && !waitrequest && address[7:2] == IDX_IRQ_FLAGS
      |-> (readdata[7:0] & ~FLAG_MASK) == 8'h00)
    else $error("flag register reads bits outside its fields");
  enable_mask_a: assert property (read && !waitrequest && address[7:2] == IDX_OUT_ENABLE
      |-> (readdata[7:0] & ~OUT_MASK) == 8'h00)
    else $error("output enable reads bits outside its fields");
  unmapped_zero_a: assert property (read && !waitrequest &&
      address[7:2] inside {[6'h06:6'h09], 6'h0C, 6'h0D} |-> readdata[7:0] == 8'h00)
    else $error("unmapped index reads nonzero");
  // Flags never clear on their own, so a falling request needs a write
  irq_drop_a: assert property ($fell(irqRequest) |-> $past(write) || $past(write, 2))
    else $error("interrupt request dropped without a write");

  cmd_write_c: cover property (write && !waitrequest && address[7:2] == IDX_CMD_SET);
  irq_rise_c: cover property ($rose(irqRequest));
  hole_read_c: cover property (read && !waitrequest && address[7:2] == 6'h07);
endmodule : split_timer_ctrl_checker

bind split_timer_ctrl split_timer_ctrl_checker split_timer_ctrl_checker_inst (
  .mclk, .rst, .address, .read, .write, .readdata, .waitrequest, .irqRequest);
`default_nettype wire

//--- split_timer_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module split_timer_ctrl_tb_top;
  import split_timer_pkg::*;

  // ======================================
  // Ports and bookkeeping
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] address = 8'h00;
  logic              read = 1'b0;
  logic              write = 1'b0;
  logic [DATA_W-1:0] writedata = 32'h00000000;
  logic [3:0]        byteenable = 4'hF;
  logic              cpuHalted = 1'b0;
  logic [5:0]        portOutValue = 6'h15;
  logic [DATA_W-1:0] readdata;
  logic              waitrequest;
  logic [5:0]        waveformOutput;
  logic              irqRequest;
  logic [7:0]        rd;
  logic [5:0]        rwIdx [5] = '{IDX_OUT_ENABLE, IDX_OUT_VALUE, IDX_IRQ_ENABLE, IDX_DEBUG_CTRL, 6'h07};
  logic [7:0]        rwExp [5] = '{OUT_MASK, OUT_MASK, FLAG_MASK, BIT0_MASK, 8'h00};
  int                errors = 0;
  int                nTests = 0;

  always #10 mclk = ~mclk;

  split_timer_ctrl split_timer_ctrl_inst (.mclk, .rst, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .cpuHalted, .portOutValue, .waveformOutput, .irqRequest);

  // ======================================
  // Bus access, held until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    read      <= ~wr;
    write     <= wr;
    address   <= {idx, 2'b00};
    writedata <= {24'h000000, wd};
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n == 50) errors++;
    rd = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
  endtask : acc

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    acc(1'b1, idx, d);
  endtask : wr

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic chk_reg(input logic [5:0] idx, input logic [7:0] exp);
    acc(1'b0, idx, 8'h00);
    cmp(rd, exp);
  endtask : chk_reg

  // Pins lag their cause by up to three cycles, so let them settle first
  task automatic chk_pin(input logic [6:0] exp);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    cmp({1'b0, irqRequest, waveformOutput}, {1'b0, exp});
  endtask : chk_pin

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  // ======================================
  // Tests
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    chk_reg(IDX_SPLIT_CFG, 8'h00);
    wr(IDX_OUT_ENABLE, 8'h77);
    chk_reg(IDX_OUT_ENABLE, 8'h00);
    wr(IDX_SPLIT_CFG, 8'h01);
    chk_reg(IDX_SPLIT_CFG, 8'h01);
    chk_reg(IDX_CMD_SET, 8'h00);
    chk_reg(IDX_IRQ_FLAGS, 8'h00);
    for (int i = 0; i < 5; i++) begin
      chk_reg(rwIdx[i], 8'h00);
      wr(rwIdx[i], 8'hFF);
      chk_reg(rwIdx[i], rwExp[i]);
    end
    done("registers");
    chk_pin(7'h3F);
    wr(IDX_OUT_VALUE, 8'h52);
    chk_pin(7'h2A);
    wr(IDX_OUT_ENABLE, 8'h05);
    chk_pin(7'h10);
    wr(IDX_OUT_ENABLE, 8'h50);
    chk_pin(7'h3D);
    done("pins");
    wr(IDX_CMD_SET, 8'h05);
    chk_reg(IDX_CMD_CLEAR, 8'h01);
    wr(IDX_CMD_SET, 8'h06);
    chk_reg(IDX_CMD_SET, 8'h03);
    chk_reg(IDX_OUT_ENABLE, 8'h50);
    wr(IDX_CMD_CLEAR, 8'h09);
    chk_reg(IDX_CMD_SET, 8'h02);
    wr(IDX_CMD_SET, 8'h0C);
    chk_reg(IDX_OUT_ENABLE, 8'h50);
    wr(IDX_CMD_SET, 8'h0D);
    chk_reg(IDX_OUT_ENABLE, 8'h00);
    chk_reg(IDX_IRQ_ENABLE, 8'h00);
    chk_reg(IDX_DEBUG_CTRL, 8'h01);
    wr(IDX_CTRL_A, 8'h0F);
    wr(IDX_OUT_ENABLE, 8'h11);
    wr(IDX_CMD_SET, 8'h0F);
    chk_reg(IDX_OUT_ENABLE, 8'h11);
    done("commands");
    wr(IDX_LOW_PERIOD, 8'h04);
    wr(IDX_CMD_SET, 8'h08);
    repeat (400) @(posedge mclk);
    chk_reg(IDX_LOW_COUNT, 8'h00);
    repeat (700) @(posedge mclk);
    chk_reg(IDX_LOW_COUNT, 8'h04);
    chk_reg(IDX_HIGH_COUNT, 8'hFF);
    chk_reg(IDX_IRQ_FLAGS, 8'h73);
    // Match set channels 0 and 3, the underflow a cycle later cleared them again
    chk_pin(7'h14);
    done("prescale");
    wr(IDX_CTRL_A, 8'h00);
    wr(IDX_OUT_ENABLE, 8'h00);
    wr(IDX_IRQ_FLAGS, 8'h00);
    chk_reg(IDX_IRQ_FLAGS, 8'h73);
    wr(IDX_IRQ_ENABLE, 8'h01);
    chk_pin(7'h55);
    wr(IDX_IRQ_FLAGS, 8'h01);
    chk_pin(7'h15);
    chk_reg(IDX_IRQ_FLAGS, 8'h72);
    wr(IDX_IRQ_ENABLE, 8'h02);
    chk_pin(7'h55);
    wr(IDX_IRQ_FLAGS, 8'h02);
    chk_pin(7'h15);
    for (int i = 0; i < 3; i++) begin
      wr(IDX_IRQ_ENABLE, 8'h10 << i);
      chk_pin(7'h55);
      wr(IDX_IRQ_FLAGS, 8'h10 << i);
      chk_pin(7'h15);
    end
    done("flags");
    wr(IDX_DEBUG_CTRL, 8'h00);
    cpuHalted <= 1'b1;
    wr(IDX_CTRL_A, 8'h01);
    wr(IDX_LOW_COUNT, 8'h80);
    repeat (20) @(posedge mclk);
    chk_reg(IDX_LOW_COUNT, 8'h80);
    wr(IDX_DEBUG_CTRL, 8'h01);
    repeat (20) @(posedge mclk);
    acc(1'b0, IDX_LOW_COUNT, 8'h00);
    cmp({7'h00, rd inside {[8'h51:8'h7F]}}, 8'h01);
    cpuHalted <= 1'b0;
    done("debug");
    final_report();
  end

  // Whole run is under two thousand cycles; this only cuts a hang
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    final_report();
  end
endmodule : split_timer_ctrl_tb_top
`default_nettype wire

//--- split_timer_pkg.sv
`default_nettype none
package split_timer_pkg;

  // ==========================================
  // Bus shape
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int IDX_W  = 6;
  localparam int CHANNELS = 3;

  // ==========================================
  // Register indices, byte address is index times four
  localparam logic [IDX_W-1:0] IDX_CTRL_A      = 6'h00;
  localparam logic [IDX_W-1:0] IDX_OUT_ENABLE  = 6'h01;
  localparam logic [IDX_W-1:0] IDX_OUT_VALUE   = 6'h02;
  localparam logic [IDX_W-1:0] IDX_SPLIT_CFG   = 6'h03;
  localparam logic [IDX_W-1:0] IDX_CMD_CLEAR   = 6'h04;
  localparam logic [IDX_W-1:0] IDX_CMD_SET     = 6'h05;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE  = 6'h0A;
  localparam logic [IDX_W-1:0] IDX_IRQ_FLAGS   = 6'h0B;
  localparam logic [IDX_W-1:0] IDX_DEBUG_CTRL  = 6'h0E;
  localparam logic [IDX_W-1:0] IDX_LOW_COUNT   = 6'h20;
  localparam logic [IDX_W-1:0] IDX_HIGH_COUNT  = 6'h21;
  localparam logic [IDX_W-1:0] IDX_LOW_PERIOD  = 6'h26;
  localparam logic [IDX_W-1:0] IDX_HIGH_PERIOD = 6'h27;
  localparam logic [IDX_W-1:0] IDX_CMP_FIRST   = 6'h28;
  localparam logic [IDX_W-1:0] IDX_CMP_LAST    = 6'h2D;

  // ==========================================
  // Field positions and masks
  localparam int ENABLE_BIT    = 0;
  localparam int PRESC_LSB     = 1;
  localparam int SPLIT_BIT     = 0;
  localparam int RUN_HALT_BIT  = 0;
  localparam int CMD_LSB       = 2;
  localparam int TARGET_LSB    = 0;
  localparam int LOW_UNF_BIT   = 0;
  localparam int HIGH_UNF_BIT  = 1;
  localparam int LOW_CMP_LSB   = 4;
  localparam int HIGH_OUT_LSB  = 4;
  localparam logic [7:0] CTRL_A_MASK = 8'h0F;
  localparam logic [7:0] OUT_MASK    = 8'h77;
  localparam logic [7:0] FLAG_MASK   = 8'h73;
  localparam logic [7:0] BIT0_MASK   = 8'h01;

  // ==========================================
  // Reset values
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hFF;

  // ==========================================
  // Commands and targets
  typedef enum logic [1:0] {
    CMD_NONE       = 2'b00,
    CMD_RESERVED   = 2'b01,
    CMD_RESTART    = 2'b10,
    CMD_HARD_RESET = 2'b11
  } command_e;
  localparam logic [1:0] TARGET_NONE = 2'h0;
  localparam logic [1:0] TARGET_BOTH = 2'h3;

  // ==========================================
  // Prescaler: tick when the masked count bits are all ones
  localparam int PRESC_W = 10;
  localparam logic [PRESC_W-1:0] PRESCALE_MASK [8] = '{
    10'h000, 10'h001, 10'h003, 10'h007,
    10'h00F, 10'h03F, 10'h0FF, 10'h3FF
  };

endpackage : split_timer_pkg
`default_nettype wire
